// ### logic/drgt_top.sv
// Global and refresh DRAM timing: registers, row/column strobe sequencing
`timescale 1ns/1ps
`include "drgt_params.svh"

// Function
// - All timing counts in memory clock cycles; strobes launched from rising edge.
// - Row strobe span timed in 128-cycle units; expiry closes row after transaction.
// - Span field zero means no page stays open between transactions.
// - Precharge of at least field plus two cycles before strobe reasserts.
// - All bank sets refreshed together, column strobe before row strobe.
// - Writing force bit gives one refresh, restarts interval counter, reads zero.
// - Periodic refresh every N times 64 cycles; N resets to one.
// - Refresh row strobe held width plus three; column released with it.
// - Refresh column strobe leads row strobe by lead field plus two.
// - Inhibit bit stops periodic refresh; forced refresh still runs.
module drgt_top (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   rst,
  // Register port
  input  wire logic [`DRGT_ADDR_W-1:0] reg_addr,
  input  wire logic [15:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [15:0]            reg_rdata,
  // Access link to the memory controller
  input  wire logic                   acc_req,
  input  wire logic [1:0]             acc_bank,
  input  wire logic                   acc_col,
  input  wire logic                   acc_done,
  output logic                        acc_ack,
  output logic                        page_open,
  output logic                        refresh_busy,
  // DRAM strobes, one per bank set
  output logic      [3:0]             row_strobe_n,
  output logic      [3:0]             col_strobe_n
);

  drgt_pkg::drgt_top_st_t st_q;
  drgt_pkg::drgt_top_st_t st_d;

  logic span_restart;
  logic span_expired;
  logic ref_restart;
  logic ref_tick;
  logic wr_global;
  logic wr_refresh;
  logic force_wr;
  logic ref_set;
  logic ref_clr;

  // One-hot strobe pattern for a bank set
  function automatic logic [3:0] bank_sel(input logic [1:0] b);
    bank_sel = 4'h1 << b;
  endfunction

  // Down counter reaches its last cycle
  function automatic logic cnt_last(input logic [3:0] c);
    cnt_last = (c <= 4'h1);
  endfunction

  // Register read mux
  function automatic logic [15:0] read_word(input logic [`DRGT_ADDR_W-1:0] a,
                                            input drgt_pkg::drgt_top_st_t s);
    read_word = 16'h0000;
    if (a == `DRGT_GLOBAL_ADDR) begin
      read_word[`DRGT_SPAN_HI:`DRGT_SPAN_LO] = s.span;
      read_word[`DRGT_PRE_HI:`DRGT_PRE_LO]   = s.pre;
    end else if (a == `DRGT_REFRESH_ADDR) begin
      read_word[`DRGT_INT_HI:`DRGT_INT_LO]   = s.interval;
      read_word[`DRGT_RW_HI:`DRGT_RW_LO]     = s.ref_width;
      read_word[`DRGT_LEAD_HI:`DRGT_LEAD_LO] = s.ref_lead;
      read_word[`DRGT_INH_BIT]               = s.inhibit;
    end
  endfunction

  // Address decode
  always_comb begin
    wr_global  = 1'b0;
    wr_refresh = 1'b0;
    if (reg_wr && reg_addr == `DRGT_GLOBAL_ADDR) begin
      wr_global = 1'b1;
    end else if (reg_wr && reg_addr == `DRGT_REFRESH_ADDR) begin
      wr_refresh = 1'b1;
    end
  end

  assign force_wr = wr_refresh && reg_wdata[`DRGT_FORCE_BIT];

  assign ref_restart = force_wr;

  assign ref_set = force_wr || (ref_tick && !st_q.inhibit);

  drgt_refresh_timer u_refresh_timer (
    .clock    (clock),
    .rst      (rst),
    .restart  (ref_restart),
    .interval (st_q.interval),
    .tick     (ref_tick)
  );

  drgt_span_timer u_span_timer (
    .clock      (clock),
    .rst        (rst),
    .restart    (span_restart),
    .span_units (st_q.span),
    .expired    (span_expired)
  );

  always_comb begin
    st_d         = st_q;
    span_restart = 1'b0;
    ref_clr      = 1'b0;

    // Register writes
    if (wr_global) begin
      st_d.span = reg_wdata[`DRGT_SPAN_HI:`DRGT_SPAN_LO];
      st_d.pre  = reg_wdata[`DRGT_PRE_HI:`DRGT_PRE_LO];
    end
    if (wr_refresh) begin
      st_d.interval  = reg_wdata[`DRGT_INT_HI:`DRGT_INT_LO];
      st_d.ref_width = reg_wdata[`DRGT_RW_HI:`DRGT_RW_LO];
      st_d.ref_lead  = reg_wdata[`DRGT_LEAD_HI:`DRGT_LEAD_LO];
      st_d.inhibit   = reg_wdata[`DRGT_INH_BIT];
    end

    // Read data stand only in the cycle after the strobe
    st_d.rdata = reg_rd ? read_word(reg_addr, st_q) : 16'h0000;

    // Precharge and refresh sequence countdowns
    if (st_q.pre_cnt != 4'h0) begin
      st_d.pre_cnt = st_q.pre_cnt - 4'h1;
    end
    if (st_q.seq_cnt != 4'h0) begin
      st_d.seq_cnt = st_q.seq_cnt - 4'h1;
    end

    case (st_q.state)
      drgt_pkg::DRGT_IDLE: begin
        st_d.row_n = 4'hf;
        st_d.col_n = 4'hf;
        st_d.ack   = 1'b0;
        // refresh only after precharge is met
        if (st_q.ref_pend && cnt_last(st_q.pre_cnt)) begin
          st_d.col_n    = 4'h0;
          // column leads row by field plus two
          st_d.seq_cnt  = {1'b0, st_q.ref_lead} + `DRGT_LEAD_OFS;
          st_d.ref_busy = 1'b1;
          ref_clr       = 1'b1;
          st_d.state    = drgt_pkg::DRGT_REF_COL;
        end else if (acc_req && cnt_last(st_q.pre_cnt)) begin
          st_d.row_n   = ~bank_sel(acc_bank);
          st_d.bank    = acc_bank;
          st_d.ack     = 1'b1;
          span_restart = 1'b1;
          st_d.state   = drgt_pkg::DRGT_ACTIVE;
        end
      end

      drgt_pkg::DRGT_ACTIVE: begin
        // column strobe registered to the clock
        st_d.col_n = acc_col ? ~bank_sel(st_q.bank) : 4'hf;
        if (acc_done) begin
          st_d.ack   = 1'b0;
          st_d.col_n = 4'hf;
          if (st_q.span == 3'h0 || span_expired || st_q.ref_pend) begin
            st_d.row_n   = 4'hf;
            st_d.pre_cnt = {1'b0, st_q.pre} + `DRGT_PRE_OFS;
            st_d.state   = drgt_pkg::DRGT_IDLE;
          end else begin
            st_d.page_open = 1'b1;
            st_d.state     = drgt_pkg::DRGT_HOLD;
          end
        end
      end

      drgt_pkg::DRGT_HOLD: begin
        st_d.col_n = 4'hf;
        // pending refresh closes the open page
        if (span_expired || st_q.ref_pend ||
            (acc_req && acc_bank != st_q.bank)) begin
          st_d.row_n     = 4'hf;
          st_d.page_open = 1'b0;
          st_d.pre_cnt   = {1'b0, st_q.pre} + `DRGT_PRE_OFS;
          st_d.state     = drgt_pkg::DRGT_IDLE;
        end else if (acc_req) begin
          // Page hit, row stays asserted
          st_d.ack       = 1'b1;
          st_d.page_open = 1'b0;
          st_d.state     = drgt_pkg::DRGT_ACTIVE;
        end
      end

      drgt_pkg::DRGT_REF_COL: begin
        if (cnt_last(st_q.seq_cnt)) begin
          st_d.row_n   = 4'h0;
          st_d.seq_cnt = {1'b0, st_q.ref_width} + `DRGT_RW_OFS;
          st_d.state   = drgt_pkg::DRGT_REF_ROW;
        end
      end

      drgt_pkg::DRGT_REF_ROW: begin
        if (cnt_last(st_q.seq_cnt)) begin
          st_d.row_n    = 4'hf;
          st_d.col_n    = 4'hf;
          st_d.ref_busy = 1'b0;
          st_d.pre_cnt  = {1'b0, st_q.pre} + `DRGT_PRE_OFS;
          st_d.state    = drgt_pkg::DRGT_IDLE;
        end
      end

      default: begin
        st_d.row_n = 4'hf;
        st_d.col_n = 4'hf;
        st_d.state = drgt_pkg::DRGT_IDLE;
      end
    endcase

    st_d.ref_pend = (st_q.ref_pend && !ref_clr) || ref_set;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q           <= '0;
      st_q.span      <= `DRGT_SPAN_RST;
      st_q.pre       <= `DRGT_PRE_RST;
      st_q.interval  <= `DRGT_INT_RST;
      st_q.ref_width <= `DRGT_RW_RST;
      st_q.ref_lead  <= `DRGT_LEAD_RST;
      st_q.inhibit   <= `DRGT_INH_RST;
      st_q.state     <= drgt_pkg::DRGT_IDLE;
      st_q.row_n     <= 4'hf;
      st_q.col_n     <= 4'hf;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata    = st_q.rdata;
  assign acc_ack      = st_q.ack;
  assign page_open    = st_q.page_open;
  assign refresh_busy = st_q.ref_busy;
  assign row_strobe_n = st_q.row_n;
  assign col_strobe_n = st_q.col_n;

endmodule

// ### inc/drgt_params.svh
// Constants for the global and refresh DRAM timing block
`ifndef DRGT_PARAMS_SVH
`define DRGT_PARAMS_SVH

// Register byte addresses
`define DRGT_ADDR_W         34
`define DRGT_GLOBAL_ADDR    34'h180000200
`define DRGT_REFRESH_ADDR   34'h180000220

// Global timing fields
`define DRGT_SPAN_HI        5
`define DRGT_SPAN_LO        3
`define DRGT_PRE_HI         2
`define DRGT_PRE_LO         0

// Refresh timing fields
`define DRGT_FORCE_BIT      15
`define DRGT_INT_HI         12
`define DRGT_INT_LO         7
`define DRGT_RW_HI          6
`define DRGT_RW_LO          4
`define DRGT_LEAD_HI        3
`define DRGT_LEAD_LO        1
`define DRGT_INH_BIT        0

// Reset values
`define DRGT_SPAN_RST       3'h1
`define DRGT_PRE_RST        3'h1
`define DRGT_INT_RST        6'h01
`define DRGT_RW_RST         3'h1
`define DRGT_LEAD_RST       3'h1
`define DRGT_INH_RST        1'h0

// Minimum values added to programmed fields
`define DRGT_PRE_OFS        4'h2
`define DRGT_RW_OFS         4'h3
`define DRGT_LEAD_OFS       4'h2

// Timer units as shift amounts: 128 and 64 cycles
`define DRGT_SPAN_SHIFT     7
`define DRGT_INT_SHIFT      6

`endif

// ### inc/drgt_pkg.sv
// Types shared by the DRAM global and refresh timing block
package drgt_pkg;

  typedef enum logic [2:0] {
    DRGT_IDLE,
    DRGT_ACTIVE,
    DRGT_HOLD,
    DRGT_REF_COL,
    DRGT_REF_ROW
  } drgt_state_t;

  typedef struct packed {
    logic [9:0] cnt;
    logic       expired;
  } drgt_span_st_t;

  typedef struct packed {
    logic [11:0] cnt;
    logic        tick;
  } drgt_ref_st_t;

  typedef struct packed {
    logic [2:0]  span;
    logic [2:0]  pre;
    logic [5:0]  interval;
    logic [2:0]  ref_width;
    logic [2:0]  ref_lead;
    logic        inhibit;
    logic [15:0] rdata;
    drgt_state_t state;
    logic [1:0]  bank;
    logic [3:0]  pre_cnt;
    logic [3:0]  seq_cnt;
    logic        ref_pend;
    logic [3:0]  row_n;
    logic [3:0]  col_n;
    logic        ack;
    logic        page_open;
    logic        ref_busy;
  } drgt_top_st_t;

endpackage

// ### logic/drgt_span_timer.sv
// Maximum row-strobe span timer in units of 128 cycles
`timescale 1ns/1ps
`include "drgt_params.svh"

module drgt_span_timer (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Control
  input  wire logic       restart,
  input  wire logic [2:0] span_units,
  // Status
  output logic            expired
);

  drgt_pkg::drgt_span_st_t st_q;
  drgt_pkg::drgt_span_st_t st_d;
  logic [9:0]              limit;
  logic [9:0]              cnt_inc;

  assign limit   = {span_units, {`DRGT_SPAN_SHIFT{1'b0}}};
  assign cnt_inc = st_q.cnt + 10'h001;
  assign expired = st_q.expired;

  always_comb begin
    st_d = st_q;
    if (restart) begin
      st_d.cnt     = 10'h000;
      st_d.expired = 1'b0;
    end else if (!st_q.expired) begin
      st_d.cnt = cnt_inc;
      if (cnt_inc >= limit) begin
        st_d.expired = 1'b1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// ### logic/drgt_refresh_timer.sv
// Refresh interval counter, one tick every N x 64 cycles
`timescale 1ns/1ps
`include "drgt_params.svh"

module drgt_refresh_timer (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst,
  // Control
  input  wire logic       restart,
  input  wire logic [5:0] interval,
  // Status
  output logic            tick
);

  drgt_pkg::drgt_ref_st_t st_q;
  drgt_pkg::drgt_ref_st_t st_d;
  logic [11:0]            limit;
  logic [11:0]            cnt_inc;

  assign limit   = {interval, {`DRGT_INT_SHIFT{1'b0}}};
  assign cnt_inc = st_q.cnt + 12'h001;
  assign tick    = st_q.tick;

  always_comb begin
    st_d      = st_q;
    st_d.tick = 1'b0;
    if (restart) begin
      st_d.cnt = 12'h000;
    end else if (cnt_inc >= limit) begin
      st_d.cnt  = 12'h000;
      st_d.tick = 1'b1;
    end else begin
      st_d.cnt = cnt_inc;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

// ### bench/drgt_dram_model.sv
// Far-side model of the DRAM bank sets
`timescale 1ns/1ps

module drgt_dram_model (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // Strobes
  input  wire logic [3:0]  row_strobe_n,
  input  wire logic [3:0]  col_strobe_n,
  // Refresh cycles seen
  output logic      [15:0] ref_count
);
  logic [3:0] col_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      col_q <= 4'hf;
      ref_count <= 16'h0;
    end else begin
      col_q <= col_strobe_n;
      if (col_q == 4'hf && col_strobe_n == 4'h0 && row_strobe_n == 4'hf) begin
        ref_count <= ref_count + 16'h1;
      end
    end
  end
endmodule

// ### bench/drgt_top_props.sv
// Port checks for the global and refresh timing block
`timescale 1ns/1ps
`include "drgt_params.svh"

module drgt_top_props (
  // Clock and reset
  input wire logic                    clock,
  input wire logic                    rst,
  // Register port
  input wire logic [`DRGT_ADDR_W-1:0] reg_addr,
  input wire logic [15:0]             reg_wdata,
  input wire logic                    reg_wr,
  input wire logic                    reg_rd,
  input wire logic [15:0]             reg_rdata,
  // Access link
  input wire logic                    acc_req,
  input wire logic [1:0]              acc_bank,
  input wire logic                    acc_col,
  input wire logic                    acc_done,
  input wire logic                    acc_ack,
  input wire logic                    page_open,
  input wire logic                    refresh_busy,
  // Strobes
  input wire logic [3:0]              row_strobe_n,
  input wire logic [3:0]              col_strobe_n
);
  logic [2:0] pre_q;
  logic [2:0] span_q;
  logic [2:0] lead_q;
  logic [2:0] wid_q;
  logic [7:0] cnt_q;
  logic [7:0] gap_q;

  // Shadow fields, busy and idle counters
  always_ff @(posedge clock) begin
    if (rst) begin
      pre_q <= `DRGT_PRE_RST;
      span_q <= `DRGT_SPAN_RST;
      lead_q <= `DRGT_LEAD_RST;
      wid_q <= `DRGT_RW_RST;
      cnt_q <= 8'h0;
      gap_q <= 8'hff;
    end else begin
      if (reg_wr && reg_addr == `DRGT_GLOBAL_ADDR) begin
        span_q <= reg_wdata[5:3];
        pre_q <= reg_wdata[2:0];
      end
      if (reg_wr && reg_addr == `DRGT_REFRESH_ADDR) begin
        wid_q <= reg_wdata[6:4];
        lead_q <= reg_wdata[3:1];
      end
      cnt_q <= refresh_busy ? cnt_q + 8'h1 : 8'h0;
      gap_q <= !(&{row_strobe_n, col_strobe_n}) ? 8'h0 : (&gap_q) ? gap_q : gap_q + 8'h1;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  sequence ref_row_fall;
    $fell(row_strobe_n[0]) && refresh_busy;
  endsequence
  sequence ref_end;
    $fell(refresh_busy);
  endsequence

  a_reset_idle: assert property (disable iff (1'b0) rst |=> &row_strobe_n && &col_strobe_n && !acc_ack)
    else $error("strobes not idle after reset");
  a_force_reads_zero: assert property (reg_rd && reg_addr == `DRGT_REFRESH_ADDR |=> !reg_rdata[15])
    else $error("force bit read back as one");
  a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 16'h0)
    else $error("read data outside read cycle");
  a_ref_all_banks: assert property (refresh_busy |-> col_strobe_n == 4'h0 && row_strobe_n inside {4'h0, 4'hf})
    else $error("refresh not on all bank sets");
  a_ref_lead: assert property (ref_row_fall |-> cnt_q == {5'h0, lead_q} + 8'h2)
    else $error("column to row lead wrong");
  a_ref_release: assert property (ref_end |-> &row_strobe_n && &col_strobe_n && cnt_q == lead_q + wid_q + 8'h5)
    else $error("refresh row width wrong");
  a_precharge_gap: assert property ($fell(&{row_strobe_n, col_strobe_n}) |-> gap_q >= {5'h0, pre_q} + 8'h2)
    else $error("precharge too short");
  a_ack_no_refresh: assert property (acc_ack |-> !refresh_busy && !(&row_strobe_n))
    else $error("transaction overlaps refresh");
  a_no_page_keep: assert property ($fell(acc_ack) && span_q == 3'h0 |-> &row_strobe_n && !page_open)
    else $error("page kept open with zero span");
endmodule

bind drgt_top drgt_top_props props_u (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_bank(acc_bank),
  .acc_col(acc_col), .acc_done(acc_done), .acc_ack(acc_ack), .page_open(page_open),
  .refresh_busy(refresh_busy), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n));

// ### bench/tb_dram_refresh_global_timing.sv
// Self-checking bench for the global and refresh timing block
`timescale 1ns/1ps
`include "drgt_params.svh"
`define CHK(a, e) \
  begin \
    check_count++; \
    if ((a) !== (e)) begin \
      bad_count++; \
      $display("[FAIL] %0t got %h want %h", $time, (a), (e)); \
    end \
  end
`define WAITC(c) \
  begin \
    for (int i = 0; i < 400 && !(c); i++) begin \
      @(posedge clock); \
    end \
    if (!(c)) begin \
      bad_count++; \
      final_report(); \
    end \
  end

module tb_dram_refresh_global_timing;
  logic                    clock = 1'b0;
  logic                    rst = 1'b1;
  logic [`DRGT_ADDR_W-1:0] reg_addr = 34'h0;
  logic [15:0]             reg_wdata = 16'h0;
  logic                    reg_wr = 1'b0;
  logic                    reg_rd = 1'b0;
  logic                    acc_req = 1'b0;
  logic                    acc_col = 1'b0;
  logic                    acc_done = 1'b0;
  logic [1:0]              acc_bank = 2'h0;
  logic [15:0]             reg_rdata;
  logic [15:0]             ref_count;
  logic [15:0]             rc;
  logic                    acc_ack;
  logic                    page_open;
  logic                    refresh_busy;
  logic [3:0]              row_strobe_n;
  logic [3:0]              col_strobe_n;
  int                      bad_count = 0;
  int                      check_count = 0;
  time                     t0;
  time                     t1;

  always #12.5 clock = ~clock;

  drgt_top dut_u (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .acc_req(acc_req), .acc_bank(acc_bank), .acc_col(acc_col),
    .acc_done(acc_done), .acc_ack(acc_ack), .page_open(page_open), .refresh_busy(refresh_busy),
    .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n));
  drgt_dram_model far_u (.clock(clock), .rst(rst), .row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
    .ref_count(ref_count));

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic wr(input logic [33:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [33:0] a, input logic [15:0] e);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
    `CHK(reg_rdata, e)
  endtask

  // One transaction; f writes the force bit while it runs, and the refresh waits for it to end
  task automatic acc(input logic [1:0] b, input logic f, input logic pg);
    @(posedge clock);
    acc_req <= 1'b1;
    acc_bank <= b;
    `WAITC(acc_ack === 1'b1)
    t0 = $time;
    `CHK(row_strobe_n, ~(4'h1 << b))
    if (f) begin
      wr(`DRGT_REFRESH_ADDR, 16'h8093);
      repeat (20) @(posedge clock);
      `CHK(refresh_busy, 1'b0)
    end
    acc_col <= 1'b1;
    repeat (2) @(posedge clock);
    `CHK(col_strobe_n, ~(4'h1 << b))
    acc_done <= 1'b1;
    acc_req <= 1'b0;
    acc_col <= 1'b0;
    @(posedge clock);
    acc_done <= 1'b0;
    @(posedge clock);
    `CHK(page_open, pg)
  endtask

  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    rd(`DRGT_REFRESH_ADDR, 16'h0092);
    rd(`DRGT_GLOBAL_ADDR, 16'h0009);
    rd(34'h180000240, 16'h0);
    wr(`DRGT_REFRESH_ADDR, 16'h0093);
    repeat (80) @(posedge clock);
    rc = ref_count;
    repeat (200) @(posedge clock);
    `CHK(ref_count, rc)
    // Forced refresh still runs while inhibit stays set
    wr(`DRGT_REFRESH_ADDR, 16'h8093);
    repeat (60) @(posedge clock);
    `CHK(ref_count, rc + 16'h1)
    rd(`DRGT_REFRESH_ADDR, 16'h0093);
    wr(`DRGT_GLOBAL_ADDR, 16'h0003);
    acc(2'h2, 1'b0, 1'b0);
    `CHK(row_strobe_n, 4'hf)
    // Span of 128 cycles outlasts a transaction
    wr(`DRGT_GLOBAL_ADDR, 16'h000b);
    acc(2'h1, 1'b0, 1'b1);
    t1 = t0;
    acc(2'h1, 1'b0, 1'b1);
    `WAITC(page_open === 1'b0)
    `CHK(($time - t1) >= 127 * 25 && ($time - t1) <= 133 * 25, 1'b1)
    `CHK(row_strobe_n, 4'hf)
    rc = ref_count;
    acc(2'h0, 1'b1, 1'b0);
    `WAITC(refresh_busy === 1'b1)
    `WAITC(refresh_busy === 1'b0)
    `CHK(ref_count, rc + 16'h1)
    for (int n = 1; n <= 2; n++) begin
      // Interval never zero; one setting for every bank set
      wr(`DRGT_REFRESH_ADDR, 16'h0026 | (16'(n) << 7));
      `WAITC(refresh_busy === 1'b1)
      `WAITC(refresh_busy === 1'b0)
      `WAITC(refresh_busy === 1'b1)
      t0 = $time;
      `WAITC(refresh_busy === 1'b0)
      `WAITC(refresh_busy === 1'b1)
      `CHK($time - t0, n * 64 * 25)
      `WAITC(refresh_busy === 1'b0)
    end
    final_report();
  end
endmodule
